// file: csbc_pkg.sv
package csbc_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [11:0] AREA_BASE_IDX    = 12'h140;
  localparam logic [11:0] DEF_WAIT_IDX     = 12'h150;
  localparam logic [11:0] DEF_BUS_IDX      = 12'h151;
  localparam logic [11:0] STATUS_IDX       = 12'h152;
  // Sub-register within an area group of four
  localparam logic [1:0]  SUB_WAIT         = 2'h0;
  localparam logic [1:0]  SUB_SELECT       = 2'h1;
  localparam logic [1:0]  SUB_MASK         = 2'h2;
  localparam logic [1:0]  SUB_START        = 2'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int WRITE_WAIT_LSB  = 4;
  localparam int READ_WAIT_LSB   = 0;
  localparam int ENABLE_BIT      = 7;
  localparam int MODE_BIT        = 6;
  localparam int RECOVERY_BIT    = 4;
  localparam int MEM_TYPE_LSB    = 2;
  localparam int BUS_WIDTH_LSB   = 0;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [2:0] WAIT_RESET      = 3'h2;
  localparam logic [2:0] WAIT_PIN_CODE   = 3'h3;
  localparam logic [1:0] MEM_TYPE_RESET  = 2'h0;
  localparam logic [1:0] WIDTH_RESET     = 2'h0;
  localparam logic [3:0] ENABLE_RESET    = 4'h4;
  localparam logic [7:0] START_RESET     = 8'hff;
  localparam logic [7:0] MASK_RESET      = 8'hff;
  localparam logic [3:0] MIN_STATES      = 4'h2;
  localparam logic [3:0] RESERVED_STATES = 4'h6;
  localparam logic [2:0] DEFAULT_AREA    = 3'h4;
  localparam logic [3:0] AREA2_FIXED_TOP = 4'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_ACCESS = 3'b100
  } csbc_fsm_t;

  typedef struct packed {
    logic [4:0][2:0] write_wait_code;
    logic [4:0][2:0] read_wait_code;
    logic [3:0]      area_select_enable;
    logic            area2_decode_mode;
    logic [3:0]      recovery_dummy_enable;
    logic [4:0][1:0] memory_type_code;
    logic [4:0][1:0] bus_width_code;
    logic [3:0][7:0] start_address_bits;
    logic [3:0][7:0] mask_bits;
  } csbc_cfg_t;

  typedef struct packed {
    csbc_cfg_t   cfg;
    logic        boot_done;
    logic        wr_pend;
    logic [11:0] wr_idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    csbc_fsm_t   fsm;
    logic [3:0]  cnt;
    logic [3:0]  target;
    logic        wait_mode;
    logic [2:0]  cur_area;
    logic [2:0]  last_area;
    logic [3:0]  area_select_n;
    logic        rd_n;
    logic        wr_n;
    logic [1:0]  width;
    logic [1:0]  mem_type;
    logic        cyc_done;
  } csbc_state_t;

endpackage : csbc_pkg

// file: csbc_top.sv
// How it works
// RL1: write-wait code gives 2..6 states or wait pin
// RL2: read-wait code uses the same meanings
// RL3: all wait codes reset to three states
// RL4: area 2 enabled at reset, clearable
// RL5: areas 0, 1, 3 disabled at reset
// RL6: area 2 fixed low range until mode set
// RL7: per-area recovery bit, resets to zero
// RL8: memory type fields reset to SRAM/ROM
// RL9: bus width 00 is 8-bit, 01 16-bit
// RL10: area 2 width loaded from boot pins
// RL11: start address compares A23 to A16
// RL12: area 0 mask covers A20 to A8
// RL13: area 1 mask covers A21 to A8
// RL14: areas 2, 3 mask A22 to A15
// RL15: mask 0 compares, 1 excludes bit
// RL16: start and mask registers reset all ones
// RL17: unmatched addresses use default area settings
// RL18: recovery dummy is one state before new area
// RL19: wait-pin cycles last two states at least
// RL20: every cycle lasts at least two states
// RL21: select needs enable and full unmasked match
// RL22: software avoids reserved codes
module csbc_top (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Bus cycle request from the core
  input  wire logic        cyc_req,
  input  wire logic        cyc_write,
  input  wire logic [23:0] cyc_addr,
  output logic             cyc_done,
  // External memory side
  input  wire logic        wait_n,
  input  wire logic [1:0]  boot_width_pins,
  output logic [3:0]       area_select_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [1:0]       bus_width_code,
  output logic [1:0]       memory_type_code
);

  csbc_pkg::csbc_state_t s;
  csbc_pkg::csbc_state_t next_s;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Ones mark address bits left out of the compare. Bits below the
  // mask range never take part; bits above it always do.
  function automatic logic [23:0] csbc_mask(input logic [1:0] area,
                                            input logic [7:0] m);
    logic [23:0] r;
    r = 24'h000000;
    unique case (area)
      2'h0:    r = {3'h0, m[7:2], {6{m[1]}}, m[0], 8'hff}; // RL12
      2'h1:    r = {2'h0, m[7:2], {7{m[1]}}, m[0], 8'hff}; // RL13
      default: r = {1'h0, m, 15'h7fff};                   // RL14
    endcase
    return r;
  endfunction : csbc_mask

  // Reserved codes fall back to the slowest fixed cycle for safety
  function automatic logic [3:0] csbc_states(input logic [2:0] code);
    logic [3:0] n;
    n = csbc_pkg::RESERVED_STATES;
    unique case (code)
      3'h1:    n = 4'h2; // RL1 RL2 RL20
      3'h2:    n = 4'h3;
      3'h5:    n = 4'h4;
      3'h6:    n = 4'h5;
      3'h7:    n = 4'h6;
      default: n = csbc_pkg::RESERVED_STATES;
    endcase
    return n;
  endfunction : csbc_states

  logic [3:0] area_hit;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_hit
      logic [23:0] start_full;
      logic        match;
      assign start_full = {s.cfg.start_address_bits[gi], 16'h0000}; // RL11
      assign match = ((cyc_addr ^ start_full)
                      & ~csbc_mask(2'(gi), s.cfg.mask_bits[gi]))
                     == 24'h000000; // RL15
      if (gi == 2) begin : g_two
        // Mode 0 pins area 2 to the bottom megabyte
        assign area_hit[gi] = s.cfg.area_select_enable[gi] &&
          (s.cfg.area2_decode_mode ? match
            : cyc_addr[23:20] == csbc_pkg::AREA2_FIXED_TOP); // RL6 RL21
      end else begin : g_other
        assign area_hit[gi] = s.cfg.area_select_enable[gi]
                              && match; // RL21
      end
    end
  endgenerate

  // Lowest numbered enabled area wins an overlap
  logic [2:0] pick_area;
  always_comb begin
    pick_area = csbc_pkg::DEFAULT_AREA; // RL17
    for (int i = 3; i >= 0; i--) begin
      if (area_hit[i]) begin
        pick_area = 3'(i);
      end
    end
  end

  // ****************************************
  // Register bus and bus cycle engine
  // ****************************************
  logic        addr_phase;
  logic [11:0] rd_idx;
  logic [1:0]  rd_area;
  logic [7:0]  rd_byte;
  logic [1:0]  wr_area;
  logic [7:0]  wbyte;
  logic [2:0]  code;
  logic        finish;

  assign addr_phase = hsel && hready && htrans[1];
  assign rd_idx     = haddr[13:2];
  assign rd_area    = rd_idx[3:2];
  assign wr_area    = s.wr_idx[3:2];
  assign wbyte      = hwdata[7:0];

  always_comb begin
    next_s          = s;
    next_s.cyc_done = 1'b0;
    rd_byte         = 8'h00;
    code            = 3'h0;
    finish          = 1'b0;

    // Area 2 width follows the boot pins on the first edge after reset
    if (!s.boot_done) begin
      next_s.boot_done                 = 1'b1;
      next_s.cfg.bus_width_code[2]     = boot_width_pins; // RL10
    end

    // Data phase of a register write; upper data bits are ignored
    next_s.wr_pend = addr_phase && hwrite;
    next_s.wr_idx  = rd_idx;
    if (s.wr_pend) begin
      if (s.wr_idx[11:4] == csbc_pkg::AREA_BASE_IDX[11:4]) begin
        unique case (s.wr_idx[1:0])
          csbc_pkg::SUB_WAIT: begin
            next_s.cfg.write_wait_code[wr_area] =
              wbyte[csbc_pkg::WRITE_WAIT_LSB +: 3]; // RL1
            next_s.cfg.read_wait_code[wr_area] =
              wbyte[csbc_pkg::READ_WAIT_LSB +: 3]; // RL2
          end
          csbc_pkg::SUB_SELECT: begin
            next_s.cfg.area_select_enable[wr_area] =
              wbyte[csbc_pkg::ENABLE_BIT]; // RL4 RL5
            if (wr_area == 2'h2) begin
              next_s.cfg.area2_decode_mode =
                wbyte[csbc_pkg::MODE_BIT]; // RL6
            end
            next_s.cfg.recovery_dummy_enable[wr_area] =
              wbyte[csbc_pkg::RECOVERY_BIT]; // RL7
            next_s.cfg.memory_type_code[wr_area] =
              wbyte[csbc_pkg::MEM_TYPE_LSB +: 2]; // RL8
            next_s.cfg.bus_width_code[wr_area] =
              wbyte[csbc_pkg::BUS_WIDTH_LSB +: 2]; // RL9
          end
          csbc_pkg::SUB_MASK:  next_s.cfg.mask_bits[wr_area] = wbyte;
          csbc_pkg::SUB_START: next_s.cfg.start_address_bits[wr_area] = wbyte;
          default: ;
        endcase
      end else if (s.wr_idx == csbc_pkg::DEF_WAIT_IDX) begin
        next_s.cfg.write_wait_code[4] =
          wbyte[csbc_pkg::WRITE_WAIT_LSB +: 3]; // RL17
        next_s.cfg.read_wait_code[4] =
          wbyte[csbc_pkg::READ_WAIT_LSB +: 3];
      end else if (s.wr_idx == csbc_pkg::DEF_BUS_IDX) begin
        next_s.cfg.memory_type_code[4] =
          wbyte[csbc_pkg::MEM_TYPE_LSB +: 2];
        next_s.cfg.bus_width_code[4] =
          wbyte[csbc_pkg::BUS_WIDTH_LSB +: 2];
      end
    end

    // Reads answer in the data phase; wait and select controls are
    // write-only and read as zero, like any unmapped word
    if (rd_idx[11:4] == csbc_pkg::AREA_BASE_IDX[11:4]) begin
      if (rd_idx[1:0] == csbc_pkg::SUB_MASK) begin
        rd_byte = s.cfg.mask_bits[rd_area];
      end else if (rd_idx[1:0] == csbc_pkg::SUB_START) begin
        rd_byte = s.cfg.start_address_bits[rd_area];
      end
    end else if (rd_idx == csbc_pkg::STATUS_IDX) begin
      rd_byte = {2'h0, s.fsm, s.cur_area};
    end
    if (addr_phase && !hwrite) begin
      next_s.hrdata = {24'h000000, rd_byte};
    end
    next_s.hreadyout = 1'b1;

    unique case (s.fsm)
      csbc_pkg::ST_IDLE: begin
        // One idle state between cycles lets the core drop its request
        if (cyc_req && !s.cyc_done) begin
          code = cyc_write ? s.cfg.write_wait_code[pick_area]
                           : s.cfg.read_wait_code[pick_area];
          next_s.cur_area  = pick_area;
          next_s.wait_mode = code == csbc_pkg::WAIT_PIN_CODE; // RL19
          next_s.target    = csbc_states(code);
          next_s.width     = s.cfg.bus_width_code[pick_area]; // RL17
          next_s.mem_type  = s.cfg.memory_type_code[pick_area];
          next_s.cnt       = 4'h1;
          if (s.last_area != csbc_pkg::DEFAULT_AREA
              && s.cfg.recovery_dummy_enable[s.last_area[1:0]]
              && s.last_area != pick_area) begin
            next_s.fsm = csbc_pkg::ST_DUMMY; // RL18
          end else begin
            next_s.fsm = csbc_pkg::ST_ACCESS;
            if (pick_area != csbc_pkg::DEFAULT_AREA) begin
              next_s.area_select_n[pick_area[1:0]] = 1'b0; // RL21
            end
            next_s.rd_n = cyc_write;
            next_s.wr_n = !cyc_write;
          end
        end
      end
      csbc_pkg::ST_DUMMY: begin
        // One state with every strobe idle, so the old device can float
        next_s.fsm = csbc_pkg::ST_ACCESS; // RL18
        if (s.cur_area != csbc_pkg::DEFAULT_AREA) begin
          next_s.area_select_n[s.cur_area[1:0]] = 1'b0;
        end
        next_s.rd_n = cyc_write;
        next_s.wr_n = !cyc_write;
      end
      csbc_pkg::ST_ACCESS: begin
        if (s.wait_mode) begin
          finish = s.cnt >= csbc_pkg::MIN_STATES && wait_n; // RL19
        end else begin
          finish = s.cnt == s.target; // RL1 RL2 RL20
        end
        if (finish) begin
          next_s.fsm           = csbc_pkg::ST_IDLE;
          next_s.area_select_n = 4'hf;
          next_s.rd_n          = 1'b1;
          next_s.wr_n          = 1'b1;
          next_s.cyc_done      = 1'b1;
          next_s.last_area     = s.cur_area;
        end else if (s.cnt != 4'hf) begin
          next_s.cnt = 4'(s.cnt + 4'h1);
        end
      end
      default: next_s.fsm = csbc_pkg::ST_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cfg.write_wait_code       <= {5{csbc_pkg::WAIT_RESET}}; // RL3
      s.cfg.read_wait_code        <= {5{csbc_pkg::WAIT_RESET}}; // RL3
      s.cfg.area_select_enable    <= csbc_pkg::ENABLE_RESET; // RL4 RL5
      s.cfg.area2_decode_mode     <= 1'b0; // RL6
      s.cfg.recovery_dummy_enable <= 4'h0; // RL7
      s.cfg.memory_type_code      <= {5{csbc_pkg::MEM_TYPE_RESET}}; // RL8
      s.cfg.bus_width_code        <= {5{csbc_pkg::WIDTH_RESET}}; // RL9
      s.cfg.start_address_bits    <= {4{csbc_pkg::START_RESET}}; // RL16
      s.cfg.mask_bits             <= {4{csbc_pkg::MASK_RESET}}; // RL16
      s.hreadyout                 <= 1'b1;
      s.fsm                       <= csbc_pkg::ST_IDLE;
      s.cur_area                  <= csbc_pkg::DEFAULT_AREA;
      s.last_area                 <= csbc_pkg::DEFAULT_AREA;
      s.area_select_n             <= 4'hf;
      s.rd_n                      <= 1'b1;
      s.wr_n                      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata           = s.hrdata;
  assign hreadyout        = s.hreadyout;
  assign hresp            = 1'b0;
  assign cyc_done         = s.cyc_done;
  assign area_select_n    = s.area_select_n;
  assign rd_n             = s.rd_n;
  assign wr_n             = s.wr_n;
  assign bus_width_code   = s.width;
  assign memory_type_code = s.mem_type;

endmodule : csbc_top

// file: csbc_mem_model.sv
module csbc_mem_model (
  // Clock and strobes
  input  wire logic       hclk,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // Wait states the bench asks for
  input  wire logic [3:0] stall,
  // Wait line
  output logic            wait_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;

  always_ff @(posedge hclk) begin
    cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'h1;
  end

  // Pulled up: high whenever no strobe is active
  assign wait_n = (rd_n && wr_n) || (cnt >= stall);
endmodule : csbc_mem_model

// file: csbc_top_chk.sv
module csbc_top_chk (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Cycle handshake
  input wire logic       cyc_req,
  input wire logic       cyc_done,
  // Memory side
  input wire logic       wait_n,
  input wire logic [3:0] area_select_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [1:0] memory_type_code
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_rd_min; $fell(rd_n) |=> !rd_n; endproperty
  a_rd_min: assert property (p_rd_min) else $error("short read");
  property p_wr_min; $fell(wr_n) |-> ##1 !wr_n; endproperty
  a_wr_min: assert property (p_wr_min) else $error("short write");
  property p_done_end; $rose(rd_n) || $rose(wr_n) |-> cyc_done; endproperty
  a_done_end: assert property (p_done_end) else $error("late done");
  property p_done_pulse; cyc_done |=> !cyc_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("long done");
  property p_onehot; $onehot0(~area_select_n); endproperty
  a_onehot: assert property (p_onehot) else $error("two selects");
  property p_sel_hold; !rd_n && !$past(rd_n) |-> $stable(area_select_n);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");
  // Only one dummy state may sit between request and strobe
  property p_start; $rose(cyc_req) |-> ##[1:2] (!rd_n || !wr_n); endproperty
  a_start: assert property (p_start) else $error("slow start");
  property p_wait; (!rd_n || !wr_n) && !wait_n |=> !rd_n || !wr_n;
  endproperty
  a_wait: assert property (p_wait) else $error("wait ignored");
  property p_type; memory_type_code == 2'h0; endproperty
  a_type: assert property (p_type) else $error("bad memory type");

  c_wait: cover property (!rd_n && !wait_n);
  c_area2: cover property (!area_select_n[2] && !rd_n);
  c_write: cover property ($rose(wr_n) && cyc_done);
endmodule : csbc_top_chk

bind csbc_top csbc_top_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .cyc_req(cyc_req), .cyc_done(cyc_done),
  .wait_n(wait_n), .area_select_n(area_select_n), .rd_n(rd_n),
  .wr_n(wr_n), .memory_type_code(memory_type_code)
);

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk, hresetn, hsel, hwrite, cyc_req, cyc_write;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, bw, w_seen;
  logic [23:0] cyc_addr;
  logic [3:0]  stall, sel_n;
  logic        hrdy, cyc_done, rd_n, wr_n, wait_n, resp;
  logic [1:0]  boot;
  int          mismatches, n_compared, cycles;

  csbc_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(resp),
    .cyc_req(cyc_req), .cyc_write(cyc_write), .cyc_addr(cyc_addr),
    .cyc_done(cyc_done), .wait_n(wait_n), .boot_width_pins(boot),
    .area_select_n(sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .bus_width_code(bw), .memory_type_code()
  );
  csbc_mem_model mem (
    .hclk(hclk), .rd_n(rd_n), .wr_n(wr_n), .stall(stall), .wait_n(wait_n)
  );

  // ****************************************
  // Bus and cycle tasks
  // ****************************************
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  function automatic logic [11:0] ix(input int n, input logic [1:0] s);
    return csbc_pkg::AREA_BASE_IDX + 12'(4 * n) + {10'h0, s};
  endfunction : ix

  task automatic ahb(input logic w, input logic [11:0] i,
                     input logic [7:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {18'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hrdy !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [31:0] q;
    ahb(1'b1, i, d, q);
  endtask : wr

  task automatic rdc(input logic [11:0] i, input logic [7:0] e);
    logic [31:0] q;
    ahb(1'b0, i, 8'h00, q);
    chk(q, {24'h0, e});
    chk({31'h0, resp}, 32'h0);
  endtask : rdc

  // Outputs are registered, so values seen at an edge are last cycle's
  task automatic cyc(input logic [23:0] a, input logic w,
                     input logic [3:0] es, input int nn, input int d);
    int n;
    int k;
    logic [3:0] s;
    n = 0;
    k = 0;
    s = 4'hf;
    cyc_addr <= a;
    cyc_write <= w;
    cyc_req <= 1'b1;
    do begin
      @(posedge hclk);
      k++;
      if (!rd_n || !wr_n) begin
        n++;
        s = sel_n;
        w_seen = bw;
      end
    end while (cyc_done !== 1'b1);
    cyc_req <= 1'b0;
    @(posedge hclk);
    chk({28'h0, s}, {28'h0, es});
    chk(n, nn);
    chk(k, nn + 2 + d);
  endtask : cyc

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    for (int n = 0; n < 4; n++) begin
      rdc(ix(n, csbc_pkg::SUB_MASK), 8'hff);
      rdc(ix(n, csbc_pkg::SUB_START), 8'hff);
    end
    rdc(ix(0, csbc_pkg::SUB_WAIT), 8'h00);
    rdc(12'h3ff, 8'h00);
    cyc(24'h000100, 1'b0, 4'hb, 3, 0);
    chk({30'h0, w_seen}, 32'h1);
    cyc(24'h800000, 1'b1, 4'hf, 3, 0);
    chk({30'h0, w_seen}, 32'h0);
  endtask : t_reset

  task automatic t_codes();
    logic [2:0] c [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    wr(ix(0, csbc_pkg::SUB_START), 8'h12);
    wr(ix(0, csbc_pkg::SUB_MASK), 8'h00);
    wr(ix(0, csbc_pkg::SUB_SELECT), 8'h80);
    for (int j = 0; j < 5; j++) begin
      wr(ix(0, csbc_pkg::SUB_WAIT), {1'b0, c[j], 1'b0, c[4 - j]});
      cyc(24'h120000, 1'b1, 4'he, j + 2, 0);
      cyc(24'h120000, 1'b0, 4'he, 6 - j, 0);
    end
  endtask : t_codes

  task automatic t_mask();
    wr(ix(0, csbc_pkg::SUB_WAIT), 8'h11);
    cyc(24'h130000, 1'b0, 4'hf, 3, 0);
    cyc(24'h120100, 1'b0, 4'hf, 3, 0);
    wr(ix(0, csbc_pkg::SUB_MASK), 8'h02);
    cyc(24'h127e00, 1'b0, 4'he, 2, 0);
    wr(ix(1, csbc_pkg::SUB_START), 8'h34);
    wr(ix(1, csbc_pkg::SUB_MASK), 8'h00);
    wr(ix(1, csbc_pkg::SUB_SELECT), 8'h80);
    cyc(24'h348000, 1'b0, 4'hf, 3, 0);
    wr(ix(1, csbc_pkg::SUB_MASK), 8'h02);
    rdc(ix(1, csbc_pkg::SUB_START), 8'h34);
    cyc(24'h348000, 1'b0, 4'hd, 3, 0);
    wr(ix(3, csbc_pkg::SUB_START), 8'h56);
    wr(ix(3, csbc_pkg::SUB_MASK), 8'h00);
    wr(ix(3, csbc_pkg::SUB_SELECT), 8'h80);
    cyc(24'h560100, 1'b0, 4'h7, 3, 0);
    cyc(24'h568000, 1'b0, 4'hf, 3, 0);
    wr(ix(3, csbc_pkg::SUB_MASK), 8'h01);
    cyc(24'h568000, 1'b0, 4'h7, 3, 0);
  endtask : t_mask

  task automatic t_width();
    wr(ix(0, csbc_pkg::SUB_SELECT), 8'h81);
    cyc(24'h120000, 1'b1, 4'he, 2, 0);
    chk({30'h0, w_seen}, 32'h1);
    wr(csbc_pkg::DEF_BUS_IDX, 8'h01);
    wr(csbc_pkg::DEF_WAIT_IDX, 8'h15);
    cyc(24'h900000, 1'b0, 4'hf, 4, 0);
    chk({30'h0, w_seen}, 32'h1);
    cyc(24'h900000, 1'b1, 4'hf, 2, 0);
  endtask : t_width

  task automatic t_recovery();
    wr(ix(0, csbc_pkg::SUB_SELECT), 8'h90);
    cyc(24'h120000, 1'b0, 4'he, 2, 0);
    cyc(24'h000100, 1'b0, 4'hb, 3, 1);
    cyc(24'h120000, 1'b0, 4'he, 2, 0);
    cyc(24'h120000, 1'b0, 4'he, 2, 0);
  endtask : t_recovery

  task automatic t_area2();
    wr(ix(2, csbc_pkg::SUB_START), 8'h40);
    wr(ix(2, csbc_pkg::SUB_MASK), 8'h00);
    cyc(24'h000100, 1'b0, 4'hb, 3, 1);
    wr(ix(2, csbc_pkg::SUB_SELECT), 8'hc0);
    cyc(24'h000100, 1'b0, 4'hf, 4, 0);
    cyc(24'h400000, 1'b0, 4'hb, 3, 0);
    wr(ix(2, csbc_pkg::SUB_SELECT), 8'h40);
    cyc(24'h400000, 1'b0, 4'hf, 4, 0);
  endtask : t_area2

  task automatic t_wait_pin();
    wr(ix(0, csbc_pkg::SUB_WAIT), 8'h33);
    stall <= 4'h3;
    cyc(24'h120000, 1'b0, 4'he, 4, 0);
    stall <= 4'h0;
    cyc(24'h120000, 1'b1, 4'he, 2, 0);
  endtask : t_wait_pin

  // A second reset with other straps must reload the area 2 width
  task automatic t_reboot();
    boot <= 2'h0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(ix(3, csbc_pkg::SUB_START), 8'hff);
    cyc(24'h000100, 1'b0, 4'hb, 3, 0);
    chk({30'h0, w_seen}, 32'h0);
  endtask : t_reboot

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, cyc_req, cyc_write} = 5'h0;
    {haddr, hwdata, htrans, cyc_addr, stall} = 94'h0;
    boot = 2'h1;
    {mismatches, n_compared, cycles} = 96'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_codes();
    t_mask();
    t_width();
    t_recovery();
    t_area2();
    t_wait_pin();
    t_reboot();
    final_report();
  end
endmodule : testbench
